// file: igdc_control.sv
// Top-level control logic of the isolated gate driver.
//
// Functional notes
// - Pulses under 40 ns on both PWM inputs and reset line are rejected.
// - Both PWM inputs high forces the gate output low.
// - Desaturation fault turns switch off, alarm low, latched until reset.
// - Fault turn-off uses slow soft turn-off, not hard turn-off.
// - Alarm and gate stay latched low until cleared by reset line.
// - Undervoltage forces gate low, power-good low, recovers automatically.
// - Driver enabled while reset/enable line high and until it has been low for the filter time; pulldown disables it.
// - Reset activity is ignored during the fault mute time.
// - Alarm and power-good are open-drain pulldowns with external pullups.
// - Qualified reset releases the alarm at the reset line's rising edge.
// - Reset line low beyond filter time disables driver, activates sink.
`timescale 1ns/1ps
module igdc_control
  import igdc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pwm_noninv,
  input wire logic pwm_inv,
  input wire logic reset_enable,
  input wire logic desaturation_sense,
  input wire logic input_undervoltage_lockout,
  input wire logic output_undervoltage_lockout,
  output logic gate_source_output,
  output logic gate_sink_output,
  output logic soft_turn_off,
  output logic fault_alarm_n_oe,
  output logic fault_alarm_n_out,
  output logic power_good_oe,
  output logic power_good_out
);

  // ==========================================================
  // Input conditioning
  // ==========================================================
  logic noninv_f;
  logic inv_f;
  logic rst_en_f;
  logic desaturation_sense_s1;
  logic desaturation_sense_s2;
  logic undervoltage_lockout_in_s1;
  logic undervoltage_lockout_in_s2;
  logic undervoltage_lockout_out_s1;
  logic undervoltage_lockout_out_s2;

  igdc_deglitch #(.INIT(1'b0)) u_noninv (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(pwm_noninv),
    .filtered(noninv_f)
  );

  igdc_deglitch #(.INIT(1'b0)) u_inv (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(pwm_inv),
    .filtered(inv_f)
  );

  igdc_deglitch #(.INIT(1'b0)) u_rst_en (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(reset_enable),
    .filtered(rst_en_f)
  );

  // Lockout starts asserted so the gate stays off until supplies are seen.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      desaturation_sense_s1 <= 1'b0;
      desaturation_sense_s2 <= 1'b0;
      undervoltage_lockout_in_s1 <= 1'b1;
      undervoltage_lockout_in_s2 <= 1'b1;
      undervoltage_lockout_out_s1 <= 1'b1;
      undervoltage_lockout_out_s2 <= 1'b1;
    end else begin
      desaturation_sense_s1 <= desaturation_sense;
      desaturation_sense_s2 <= desaturation_sense_s1;
      undervoltage_lockout_in_s1 <= input_undervoltage_lockout;
      undervoltage_lockout_in_s2 <= undervoltage_lockout_in_s1;
      undervoltage_lockout_out_s1 <= output_undervoltage_lockout;
      undervoltage_lockout_out_s2 <= undervoltage_lockout_out_s1;
    end
  end

  // ==========================================================
  // Fault sequencing and enable filter
  // ==========================================================
  igdc_state_type state;
  igdc_state_type next_state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] low_count;
  logic [CNT_W-1:0] next_low_count;
  logic enabled;
  logic next_enabled;
  logic reset_qualified;
  logic next_reset_qualified;
  logic rst_en_d;
  logic lockout;

  assign lockout = undervoltage_lockout_in_s2 | undervoltage_lockout_out_s2;

  always_comb begin
    next_state = state;
    next_count = count;
    next_low_count = low_count;
    next_enabled = enabled;
    next_reset_qualified = reset_qualified;
    // Low time of the reset line, saturating at the filter time.
    if (rst_en_f) begin
      next_low_count = '0;
      next_enabled = 1'b1;
    end else if (low_count < CNT_W'(RESET_FILTER_CYCLES)) begin
      next_low_count = low_count + CNT_W'(1);
    end else begin
      next_enabled = 1'b0;
    end
    case (state)
      IGDC_RUN: begin
        next_reset_qualified = 1'b0;
        if (desaturation_sense_s2 && gate_source_output) begin
          next_state = IGDC_SOFT_OFF;
          next_count = '0;
        end
      end
      IGDC_SOFT_OFF: begin
        next_count = count + CNT_W'(1);
        if (count >= CNT_W'(SOFT_OFF_CYCLES - 1)) begin
          next_state = IGDC_MUTE;
          next_count = '0;
        end
      end
      IGDC_MUTE: begin
        // Reset line is not watched here.
        next_count = count + CNT_W'(1);
        if (count >= CNT_W'(FAULT_MUTE_CYCLES - 1)) begin
          next_state = IGDC_LATCHED;
          next_count = '0;
        end
      end
      IGDC_LATCHED: begin
        // Low time is counted only from the end of the mute window.
        if (rst_en_f) begin
          next_count = '0;
          if (reset_qualified && !rst_en_d) begin
            next_state = IGDC_RUN;
          end
        end else if (count < CNT_W'(RESET_FILTER_CYCLES)) begin
          next_count = count + CNT_W'(1);
        end else begin
          next_reset_qualified = 1'b1;
        end
      end
      default: begin
        next_state = IGDC_LATCHED;
        next_count = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= IGDC_RUN;
      count <= '0;
      low_count <= '0;
      enabled <= 1'b0;
      reset_qualified <= 1'b0;
      rst_en_d <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      low_count <= next_low_count;
      enabled <= next_enabled;
      reset_qualified <= next_reset_qualified;
      rst_en_d <= rst_en_f;
    end
  end

  // ==========================================================
  // Output stage control
  // ==========================================================
  logic next_source;
  logic next_sink;
  logic next_soft;
  logic next_fault_oe;
  logic next_pg_oe;

  always_comb begin
    next_source = noninv_f && !inv_f && enabled && (state == IGDC_RUN)
      && !lockout;
    next_soft = (state == IGDC_SOFT_OFF);
    // Hard sink is held off while the soft turn-off discharges the gate.
    next_sink = !next_source && !next_soft;
    next_fault_oe = (state != IGDC_RUN);
    next_pg_oe = lockout;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gate_source_output <= 1'b0;
      gate_sink_output <= 1'b1;
      soft_turn_off <= 1'b0;
      fault_alarm_n_oe <= 1'b0;
      fault_alarm_n_out <= 1'b0;
      power_good_oe <= 1'b1;
      power_good_out <= 1'b0;
    end else begin
      gate_source_output <= next_source;
      gate_sink_output <= next_sink;
      soft_turn_off <= next_soft;
      fault_alarm_n_oe <= next_fault_oe;
      fault_alarm_n_out <= 1'b0;
      power_good_oe <= next_pg_oe;
      power_good_out <= 1'b0;
    end
  end

endmodule : igdc_control

// file: igdc_control_test.sv
// Self-checking bench of the gate driver control block.
`timescale 1ns/1ps
module igdc_control_test;
  import igdc_pkg::*;
  logic clk = 0, sys_rst = 1, pwm_noninv = 0, pwm_inv = 0;
  logic desaturation_sense = 0, input_undervoltage_lockout = 0;
  logic output_undervoltage_lockout = 0, en = 0, fl = 0, ar = 0;
  logic reset_enable, gate_source_output, gate_sink_output, soft_turn_off;
  logic fault_alarm_n_oe, fault_alarm_n_out, power_good_oe, power_good_out;
  logic an, pg;
  logic [7:0] lf = 8'h5E;
  int n_errors = 0, checked = 0;
  wire src = gate_source_output;
  igdc_control uut (
    .clk(clk),
    .sys_rst(sys_rst),
    .pwm_noninv(pwm_noninv),
    .pwm_inv(pwm_inv),
    .reset_enable(reset_enable),
    .desaturation_sense(desaturation_sense),
    .input_undervoltage_lockout(input_undervoltage_lockout),
    .output_undervoltage_lockout(output_undervoltage_lockout),
    .gate_source_output(gate_source_output),
    .gate_sink_output(gate_sink_output),
    .soft_turn_off(soft_turn_off),
    .fault_alarm_n_oe(fault_alarm_n_oe),
    .fault_alarm_n_out(fault_alarm_n_out),
    .power_good_oe(power_good_oe),
    .power_good_out(power_good_out)
  );
  igdc_mcu_model mcu (.en(en), .fl(fl), .ar(ar), .pwm(pwm_noninv),
    .a_oe(fault_alarm_n_oe), .pg_oe(power_good_oe),
    .reset_enable(reset_enable), .alarm_n(an), .pg(pg));
  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic exp_gate(logic n, logic i);
    return n & ~i;
  endfunction : exp_gate
  task automatic chk(logic got, logic exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic conclude;
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic trip;
    desaturation_sense <= 1'b1;
    for (int k = 0; k < 40 && soft_turn_off !== 1'b1; k++) @(negedge clk);
    chk(soft_turn_off, 1'b1);
    chk(an, 1'b0);
    chk(src, 1'b0);
    @(posedge clk);
    desaturation_sense <= 1'b0;
    for (int k = 0; k < 900 && soft_turn_off === 1'b1; k++) @(negedge clk);
    chk(soft_turn_off, 1'b0);
    chk(gate_sink_output, 1'b1);
    @(posedge clk);
  endtask : trip
  initial forever #2 clk = ~clk;
  initial begin
    cyc(40000);
    n_errors++;
    conclude();
  end
  initial begin
    cyc(10);
    sys_rst <= 1'b0;
    en <= 1'b1;
    for (int k = 0; k < 60; k++) begin
      lf = lfsr(lf);
      pwm_noninv <= lf[0];
      pwm_inv <= lf[1];
      cyc(16);
      @(negedge clk);
      chk(src, exp_gate(lf[0], lf[1]));
      @(posedge clk);
    end
    pwm_noninv <= 1'b1;
    pwm_inv <= 1'b0;
    cyc(20);
    pwm_inv <= 1'b1;
    cyc(8);
    pwm_inv <= 1'b0;
    repeat (24) begin
      @(negedge clk);
      chk(src, 1'b1);
    end
    @(posedge clk);
    input_undervoltage_lockout <= 1'b1;
    cyc(10);
    @(negedge clk);
    chk(pg, 1'b0);
    chk(src, 1'b0);
    @(posedge clk);
    input_undervoltage_lockout <= 1'b0;
    output_undervoltage_lockout <= 1'b1;
    cyc(10);
    @(negedge clk);
    chk(pg, 1'b0);
    chk(src, 1'b0);
    @(posedge clk);
    output_undervoltage_lockout <= 1'b0;
    cyc(20);
    @(negedge clk);
    chk(src, 1'b1);
    chk(pg, 1'b1);
    @(posedge clk);
    trip();
    en <= 1'b0;
    cyc(300);
    en <= 1'b1;
    cyc(30);
    @(negedge clk);
    chk(an, 1'b0);
    @(posedge clk);
    cyc(FAULT_MUTE_CYCLES);
    en <= 1'b0;
    cyc(RESET_FILTER_CYCLES + 30);
    @(negedge clk);
    chk(an, 1'b0);
    @(posedge clk);
    en <= 1'b1;
    cyc(30);
    @(negedge clk);
    chk(an, 1'b1);
    chk(src, 1'b1);
    @(posedge clk);
    en <= 1'b0;
    cyc(150);
    @(negedge clk);
    chk(src, 1'b1);
    cyc(100);
    @(negedge clk);
    chk(src, 1'b0);
    @(posedge clk);
    en <= 1'b1;
    fl <= 1'b1;
    cyc(260);
    @(negedge clk);
    chk(gate_sink_output, 1'b1);
    @(posedge clk);
    fl <= 1'b0;
    ar <= 1'b1;
    cyc(30);
    trip();
    repeat (12) begin
      pwm_noninv <= 1'b0;
      cyc(300);
      pwm_noninv <= 1'b1;
      cyc(300);
    end
    @(negedge clk);
    chk(an, 1'b1);
    chk(fault_alarm_n_out, 1'b0);
    chk(power_good_out, 1'b0);
    conclude();
  end
endmodule : igdc_control_test

// file: igdc_deglitch.sv
// Two-flop synchroniser followed by a glitch filter for one input pin.
`timescale 1ns/1ps
module igdc_deglitch
  import igdc_pkg::*;
#(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin,
  output logic filtered
);

  logic sync_a;
  logic sync_b;
  logic [DG_W-1:0] count;
  logic [DG_W-1:0] next_count;
  logic next_filtered;

  // A new level is accepted only after it has stood for the filter time.
  always_comb begin
    next_count = '0;
    next_filtered = filtered;
    if (sync_b != filtered) begin
      if (count >= DG_W'(DEGLITCH_CYCLES - 1)) begin
        next_filtered = sync_b;
      end else begin
        next_count = count + DG_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_a <= INIT;
      sync_b <= INIT;
      count <= '0;
      filtered <= INIT;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      count <= next_count;
      filtered <= next_filtered;
    end
  end

endmodule : igdc_deglitch

// file: igdc_mcu_model.sv
// Controller model: enable line drive and open-drain pullups.
`timescale 1ns/1ps
module igdc_mcu_model (
  input wire logic en,
  input wire logic fl,
  input wire logic ar,
  input wire logic pwm,
  input wire logic a_oe,
  input wire logic pg_oe,
  output logic reset_enable,
  output logic alarm_n,
  output logic pg
);
  // An undriven enable line reads low through the pulldown.
  assign reset_enable = fl ? 1'b0 : ar ? pwm : en;
  assign alarm_n = !a_oe;
  assign pg = !pg_oe;
endmodule : igdc_mcu_model

// file: igdc_monitor.sv
// Assertions on the gate driver control ports.
`timescale 1ns/1ps
module igdc_monitor
  import igdc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pwm_noninv,
  input wire logic pwm_inv,
  input wire logic reset_enable,
  input wire logic input_undervoltage_lockout,
  input wire logic output_undervoltage_lockout,
  input wire logic gate_source_output,
  input wire logic gate_sink_output,
  input wire logic soft_turn_off,
  input wire logic fault_alarm_n_oe,
  input wire logic fault_alarm_n_out,
  input wire logic power_good_oe,
  input wire logic power_good_out
);
  logic [9:0] cb, cu, cl, cs;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  function automatic logic [9:0] up(logic c, logic [9:0] v);
    return (c && !sys_rst) ? v + 10'(v != 10'h3FF) : 10'h0;
  endfunction : up
  // Saturating run lengths of the conditions that the rules time.
  always_ff @(posedge clk) begin
    cb <= up(pwm_noninv & pwm_inv, cb);
    cu <= up(input_undervoltage_lockout | output_undervoltage_lockout, cu);
    cl <= up(!reset_enable, cl);
    cs <= up(soft_turn_off, cs);
  end
  property p_il; cb > 14 |-> !gate_source_output; endproperty
  a_il: assert property (p_il) else $error("interlock");
  property p_uv; cu > 6 |-> !gate_source_output && power_good_oe; endproperty
  a_uv: assert property (p_uv) else $error("lockout");
  property p_dis;
    cl > 225 && !soft_turn_off |-> gate_sink_output && !gate_source_output;
  endproperty
  a_dis: assert property (p_dis) else $error("disable");
  property p_cause;
    $rose(fault_alarm_n_oe) |-> $rose(soft_turn_off) && !gate_source_output;
  endproperty
  a_cause: assert property (p_cause) else $error("alarm cause");
  property p_soft;
    soft_turn_off |-> !gate_sink_output && !gate_source_output
      && fault_alarm_n_oe;
  endproperty
  a_soft: assert property (p_soft) else $error("soft off");
  property p_slen;
    $fell(soft_turn_off) |-> cs == SOFT_OFF_CYCLES && gate_sink_output;
  endproperty
  a_slen: assert property (p_slen) else $error("soft length");
  property p_rel;
    $fell(fault_alarm_n_oe) |-> reset_enable && $past(reset_enable, 2);
  endproperty
  a_rel: assert property (p_rel) else $error("release");
  property p_od; !fault_alarm_n_out && !power_good_out; endproperty
  a_od: assert property (p_od) else $error("open drain");
  c_trip: cover property ($rose(soft_turn_off));
  c_clear: cover property ($fell(fault_alarm_n_oe));
  c_uv: cover property (cu == 10'h8);
endmodule : igdc_monitor
bind igdc_control igdc_monitor mon (.*);

// file: igdc_pkg.sv
// Package of timing constants and states for the gate driver control block.
package igdc_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int CLK_PERIOD_PS = 4000;
  localparam int DEGLITCH_TIME_NS = 40;
  localparam int DEGLITCH_CYCLES = (DEGLITCH_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int FAULT_MUTE_TIME_NS = 20000;
  localparam int FAULT_MUTE_CYCLES =
    (FAULT_MUTE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_FILTER_TIME_NS = 800;
  localparam int RESET_FILTER_CYCLES =
    (RESET_FILTER_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SOFT_OFF_TIME_NS = 2000;
  localparam int SOFT_OFF_CYCLES =
    (SOFT_OFF_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 16;
  localparam int DG_W = 4;

  // ==========================================================
  // Fault states
  // ==========================================================
  typedef enum logic [1:0] {
    IGDC_RUN,
    IGDC_SOFT_OFF,
    IGDC_MUTE,
    IGDC_LATCHED
  } igdc_state_type;

endpackage : igdc_pkg
